// *** rtl/eirp_host.sv ***
// Bus master for the EEPROM read path, ordered over AXI4-Lite
`timescale 1ns/1ps
`default_nettype none
module eirp_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // AXI4-Lite write
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [eirp_pkg::AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [eirp_pkg::AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Two-wire bus
  eirp_if.host bus
);
  import eirp_pkg::*;

  typedef enum logic [1:0] {TK_START, TK_STOP, TK_WR, TK_RD} eirp_tok_t;

  logic aw_h_r, w_h_r, bvalid_r, rvalid_r;
  logic [AXI_AW-1:0] awaddr_r;
  logic [31:0] wdata_r, wmask_r, cmd_r, addr_reg_r, rdata_r, wmask;
  logic [1:0] bresp_r, rresp_r;
  logic busy_r, nack_r, locked_r, scl_r, drv_r, ackbit_r;
  logic [8:0] cnt_rd_r;
  logic [7:0] rx_r, last_r, left_r, qdiv_r, wr_byte;
  logic [3:0] step_r, bit_r, step_nxt;
  logic [1:0] q_r;
  logic [2:0] sda_q;
  logic [3:0] sel_hi;
  logic tick, tk_done, bitval, go;
  eirp_tok_t tok;

  assign wmask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                  {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
  assign s_axi_awready = !aw_h_r && !bvalid_r;
  assign s_axi_wready = !w_h_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
  assign go = aw_h_r && w_h_r && awaddr_r == REG_CMD && !busy_r;

  // Address and data may arrive in either order; answer once both held
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_h_r <= 1'b0;
      w_h_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      awaddr_r <= '0;
      wdata_r <= 32'h0;
      wmask_r <= 32'h0;
      cmd_r <= 32'h0;
      addr_reg_r <= 32'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_h_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_h_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wmask_r <= wmask;
      end
      if (aw_h_r && w_h_r) begin
        aw_h_r <= 1'b0;
        w_h_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= RESP_OKAY;
        // A command written while busy is dropped
        if (go) begin
          cmd_r <= (cmd_r & ~wmask_r) | (wdata_r & wmask_r);
        end else if (awaddr_r == REG_ADDR) begin
          addr_reg_r <= (addr_reg_r & ~wmask_r) | (wdata_r & wmask_r);
        end else if (awaddr_r != REG_CMD) begin
          bresp_r <= RESP_SLVERR;
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      unique case (s_axi_araddr)
        REG_CMD: rdata_r <= cmd_r;
        REG_ADDR: rdata_r <= addr_reg_r;
        REG_STAT: rdata_r <= {15'h0, cnt_rd_r, 5'h0, locked_r, nack_r, busy_r};
        REG_RDATA: rdata_r <= {24'h0, last_r};
        default: begin
          rdata_r <= 32'h0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sda_q <= 3'h7;
    end else begin
      sda_q <= {sda_q[1:0], bus.sda};
    end
  end

  // Token sequence per step: random 0-7, current 4-7, lock 0-3,8,9,7
  always_comb begin
    sel_hi = cmd_r[CMD_ID] ? TYPE_ID : TYPE_MEM;
    unique case (step_r)
      4'h0, 4'h4, 4'h9: tok = TK_START;
      4'h6: tok = TK_RD;
      4'h7: tok = TK_STOP;
      default: tok = TK_WR;
    endcase
    unique case (step_r)
      4'h2: wr_byte = addr_reg_r[15:8];
      4'h3: wr_byte = addr_reg_r[7:0];
      4'h5: wr_byte = {sel_hi, cmd_r[CMD_CE_LSB+1:CMD_CE_LSB], addr_reg_r[16], 1'b1};
      4'h8: wr_byte = LOCKQ_DATA;
      default: wr_byte = {sel_hi, cmd_r[CMD_CE_LSB+1:CMD_CE_LSB], addr_reg_r[16], 1'b0};
    endcase
    // Last byte of a read goes unacknowledged
    if (bit_r == 4'h8) begin
      bitval = (tok == TK_RD) ? (left_r == 8'h00) : 1'b1;
    end else begin
      bitval = (tok == TK_RD) ? 1'b1 : wr_byte[3'h7 - bit_r[2:0]];
    end
    unique case (step_r)
      4'h3: step_nxt = (cmd_r[CMD_OP_LSB+1:CMD_OP_LSB] == OP_LOCK) ? 4'h8 : 4'h4;
      4'h6: step_nxt = (left_r == 8'h00) ? 4'h7 : 4'h6;
      4'h8: step_nxt = 4'h9;
      4'h9: step_nxt = 4'h7;
      default: step_nxt = step_r + 4'h1;
    endcase
  end

  assign tick = busy_r && qdiv_r == 8'(SCL_QTR - 1);
  assign tk_done = tick && q_r == 2'h3 && (tok == TK_START || tok == TK_STOP || bit_r == 4'h8);

  // Each token is four quarter periods per bit; start and stop take one bit time
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      locked_r <= 1'b0;
      cnt_rd_r <= 9'h000;
      last_r <= 8'h00;
      left_r <= 8'h00;
      rx_r <= 8'h00;
      ackbit_r <= 1'b1;
      step_r <= 4'h0;
      bit_r <= 4'h0;
      q_r <= 2'h0;
      qdiv_r <= 8'h00;
      scl_r <= 1'b1;
      drv_r <= 1'b0;
    end else if (!busy_r) begin
      qdiv_r <= 8'h00;
      q_r <= 2'h0;
      bit_r <= 4'h0;
      if (go) begin
        busy_r <= 1'b1;
        nack_r <= 1'b0;
        locked_r <= 1'b0;
        cnt_rd_r <= 9'h000;
        left_r <= wdata_r[CMD_LEN_LSB+7:CMD_LEN_LSB];
        if (wdata_r[CMD_ID] && wdata_r[CMD_LEN_LSB+7:CMD_LEN_LSB] > 8'hFF - addr_reg_r[7:0]) begin
          left_r <= 8'hFF - addr_reg_r[7:0];
        end
        // Current read only on explicit order; random read reloads the counter
        step_r <= (wdata_r[CMD_OP_LSB+1:CMD_OP_LSB] == OP_CUR) ? 4'h4 : 4'h0;
      end
    end else begin
      qdiv_r <= tick ? 8'h00 : qdiv_r + 8'h01;
      if (tick) begin
        q_r <= q_r + 2'h1;
        unique case (q_r)
          2'h0: drv_r <= (tok == TK_START) ? 1'b0 : (tok == TK_STOP) ? 1'b1 : !bitval;
          2'h1: scl_r <= 1'b1;
          2'h2: begin
            if (tok == TK_START) begin
              drv_r <= 1'b1;
            end else if (tok == TK_STOP) begin
              drv_r <= 1'b0;
            end else if (bit_r == 4'h8) begin
              ackbit_r <= sda_q[2];
            end else begin
              rx_r <= {rx_r[6:0], sda_q[2]};
            end
          end
          default: begin
            if (tok != TK_STOP) begin
              scl_r <= 1'b0;
            end
            bit_r <= (tk_done || tok == TK_START) ? 4'h0 : bit_r + 4'h1;
          end
        endcase
      end
      if (tk_done) begin
        step_r <= step_nxt;
        if (tok == TK_STOP) begin
          busy_r <= 1'b0;
        end else if (tok == TK_RD) begin
          last_r <= rx_r;
          cnt_rd_r <= cnt_rd_r + 9'h001;
          left_r <= left_r - 8'h01;
        end else if (tok == TK_WR && step_r == 4'h8) begin
          locked_r <= ackbit_r;
        end else if (tok == TK_WR && ackbit_r) begin
          nack_r <= 1'b1;
          step_r <= 4'h7;
        end
      end
    end
  end

  assign bus.scl = scl_r;
  assign bus.host_sda_o = 1'b0;
  assign bus.host_sda_oe = drv_r;
endmodule : eirp_host
`default_nettype wire

// *** include/eirp_pkg.sv ***
// Shared constants for the EEPROM read path target and its bus master
package eirp_pkg;
  // System clock and serial clock timing
  localparam int CLK_NS = 10;
  localparam int SCL_PERIOD_NS = 2500;
  localparam int SCL_QTR = SCL_PERIOD_NS / (4 * CLK_NS);
  // Array geometry and contents
  localparam int MEM_AW = 17;
  localparam int MEM_BYTES = 131072;
  localparam int ID_BYTES = 256;
  localparam logic [7:0] ERASED = 8'hFF;
  // Select code layout
  localparam logic [3:0] TYPE_MEM = 4'hA;
  localparam logic [3:0] TYPE_ID = 4'hB;
  localparam int SEL_TYPE_LSB = 4;
  localparam int SEL_CE_LSB = 2;
  localparam int SEL_A16 = 1;
  localparam int SEL_RW = 0;
  // Data byte sent by the lock status query
  localparam logic [7:0] LOCKQ_DATA = 8'h00;
  // Controller registers on AXI4-Lite
  localparam int AXI_AW = 5;
  localparam logic [4:0] REG_CMD = 5'h00;
  localparam logic [4:0] REG_ADDR = 5'h04;
  localparam logic [4:0] REG_STAT = 5'h08;
  localparam logic [4:0] REG_RDATA = 5'h0C;
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_ID = 2;
  localparam int CMD_CE_LSB = 4;
  localparam int CMD_LEN_LSB = 8;
  localparam int STAT_BUSY = 0;
  localparam int STAT_NACK = 1;
  localparam int STAT_LOCKED = 2;
  localparam int STAT_CNT_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] OP_CUR = 2'h0;
  localparam logic [1:0] OP_RAND = 2'h1;
  localparam logic [1:0] OP_LOCK = 2'h2;
endpackage : eirp_pkg

// *** include/eirp_if.sv ***
// Two-wire bus joining the EEPROM target and its bus master
`timescale 1ns/1ps
`default_nettype none
interface eirp_if;
  logic scl;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  wire sda;
  // Open drain with pull-up: any enabled low driver wins
  assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (output scl, input sda, output host_sda_o, output host_sda_oe);
endinterface : eirp_if
`default_nettype wire

// *** rtl/eirp_dev.sv ***
// Serial EEPROM target: read path, ident page and lock status query
// What this block and its bus master do
// - Reads ignore the write protect input.
// - Completed read advances address counter by one.
// - Release data, sample master ack in bit nine.
// - Missing master ack returns device to standby.
// - Master random read: dummy write, restart, read.
// - Ack read select, send byte at loaded address.
// - Master ends single read with nack, stop.
// - Current read: ack, send counter byte, increment.
// - One counter shared by memory and ident page.
// - Master prefers random reads for memory access.
// - Each master ack sends next consecutive byte.
// - Master ends sequential read with nack, stop.
// - Counter wraps past top address to zero.
// - Ident page uses type 1011b, low byte.
// - Master never reads past ident page end on random reads.
// - Lock query data acked only when unlocked.
// - Start resets logic, stop returns to standby.
// - All bytes read FFh when delivered.
// - Respond only when chip enable bits match.
// - Seventeen address bits, top bit in select.
// - Busy internal write ignores the bus entirely.
`timescale 1ns/1ps
`default_nettype none
module eirp_dev (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Two-wire bus
  eirp_if.dev bus,
  // Device pins
  input wire logic chip_enable_pin_low,
  input wire logic chip_enable_pin_high,
  input wire logic write_protect_input,
  input wire logic write_busy,
  input wire logic ident_locked,
  // Content preload
  input wire logic load_en,
  input wire logic load_id,
  input wire logic [eirp_pkg::MEM_AW-1:0] load_addr,
  input wire logic [7:0] load_data,
  // Observation
  output logic [eirp_pkg::MEM_AW-1:0] addr_counter,
  output logic dev_active
);
  import eirp_pkg::*;

  typedef enum logic [2:0] {ST_IDLE, ST_SEL, ST_AHI, ST_ALO, ST_WDAT, ST_TX} eirp_state_t;

  eirp_state_t state_r;
  logic [2:0] scl_q;
  logic [2:0] sda_q;
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] tx_r;
  logic [7:0] ahi_r;
  logic [MEM_AW-1:0] addr_r;
  logic a16_r;
  logic id_r;
  logic rd_r;
  logic mack_r;
  logic drv_r;
  // Stored inverted: zero-filled two-state storage then reads as erased
  bit [7:0] mem [MEM_BYTES];
  bit [7:0] idp [ID_BYTES];
  logic scl_rise;
  logic scl_fall;
  logic start_c;
  logic stop_c;
  logic sel_match;
  logic sel_is_id;
  logic [MEM_AW-1:0] addr_inc;
  logic [7:0] cur_byte;
  logic [7:0] nxt_byte;

  // Both lines pass two flops; the third stage serves edge detection and sda bit sampling
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 3'h7;
      sda_q <= 3'h7;
    end else begin
      scl_q <= {scl_q[1:0], bus.scl};
      sda_q <= {sda_q[1:0], bus.sda};
    end
  end

  assign scl_rise = scl_q[1] && !scl_q[2];
  assign scl_fall = !scl_q[1] && scl_q[2];
  assign start_c = scl_q[1] && scl_q[2] && sda_q[2] && !sda_q[1];
  assign stop_c = scl_q[1] && scl_q[2] && !sda_q[2] && sda_q[1];

  assign sel_is_id = sh_r[7:SEL_TYPE_LSB] == TYPE_ID;
  assign sel_match = (sh_r[7:SEL_TYPE_LSB] == TYPE_MEM || sel_is_id) &&
                     sh_r[SEL_CE_LSB+1:SEL_CE_LSB] ==
                     {chip_enable_pin_high, chip_enable_pin_low};
  assign addr_inc = MEM_AW'(addr_r + 1'b1);
  assign cur_byte = ERASED ^ (id_r ? idp[addr_r[7:0]] : mem[addr_r]);
  assign nxt_byte = ERASED ^ (id_r ? idp[addr_inc[7:0]] : mem[addr_inc]);

  // Preload is a back door for the bench; one writer keeps the arrays single-driven
  always_ff @(posedge clk_sys) begin
    if (load_en && load_id) begin
      idp[load_addr[7:0]] <= load_data ^ ERASED;
    end
    if (load_en && !load_id) begin
      mem[load_addr] <= load_data ^ ERASED;
    end
  end

  // Bit-level protocol; outputs change after a falling clock edge, or on start, stop or write_busy
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'hFF;
      ahi_r <= 8'h00;
      addr_r <= '0;
      a16_r <= 1'b0;
      id_r <= 1'b0;
      rd_r <= 1'b0;
      mack_r <= 1'b0;
      drv_r <= 1'b0;
    end else if (write_busy) begin
      state_r <= ST_IDLE;
      drv_r <= 1'b0;
    end else if (start_c) begin
      // Also discards a truncated write such as the lock query
      state_r <= ST_SEL;
      // Wraps to zero on the clock fall that closes the start
      cnt_r <= 4'hF;
      drv_r <= 1'b0;
    end else if (stop_c) begin
      state_r <= ST_IDLE;
      drv_r <= 1'b0;
    end else if (state_r != ST_IDLE) begin
      if (scl_rise) begin
        if (cnt_r < 4'h8) begin
          sh_r <= {sh_r[6:0], sda_q[2]};
        end else if (state_r == ST_TX) begin
          mack_r <= !sda_q[2];
        end
      end else if (scl_fall) begin
        if (state_r == ST_TX) begin
          if (cnt_r < 4'h7) begin
            cnt_r <= cnt_r + 4'h1;
            drv_r <= !tx_r[6];
            tx_r <= {tx_r[6:0], 1'b1};
          end else if (cnt_r == 4'h7) begin
            cnt_r <= 4'h8;
            drv_r <= 1'b0;
          end else begin
            // Counter moves on whether or not the master acks
            addr_r <= addr_inc;
            if (mack_r) begin
              tx_r <= nxt_byte;
              drv_r <= !nxt_byte[7];
              cnt_r <= 4'h0;
            end else begin
              state_r <= ST_IDLE;
              drv_r <= 1'b0;
            end
          end
        end else if (cnt_r == 4'h7) begin
          cnt_r <= 4'h8;
          unique case (state_r)
            ST_SEL: begin
              if (sel_match) begin
                drv_r <= 1'b1;
                id_r <= sel_is_id;
                rd_r <= sh_r[SEL_RW];
                if (!sh_r[SEL_RW]) begin
                  a16_r <= sh_r[SEL_A16];
                end
              end else begin
                state_r <= ST_IDLE;
              end
            end
            ST_AHI: begin
              drv_r <= 1'b1;
              ahi_r <= sh_r;
            end
            ST_ALO: begin
              drv_r <= 1'b1;
              if (id_r) begin
                addr_r <= {9'h000, sh_r};
              end else begin
                addr_r <= {a16_r, ahi_r, sh_r};
              end
            end
            ST_WDAT: begin
              // Write protect matters only here, never on reads
              drv_r <= id_r ? !ident_locked : !write_protect_input;
            end
            default: begin
              drv_r <= 1'b0;
            end
          endcase
        end else if (cnt_r == 4'h8) begin
          cnt_r <= 4'h0;
          drv_r <= 1'b0;
          unique case (state_r)
            ST_SEL: begin
              if (rd_r) begin
                state_r <= ST_TX;
                tx_r <= cur_byte;
                drv_r <= !cur_byte[7];
              end else begin
                state_r <= ST_AHI;
              end
            end
            ST_AHI: state_r <= ST_ALO;
            ST_ALO: state_r <= ST_WDAT;
            default: state_r <= ST_WDAT;
          endcase
        end else begin
          cnt_r <= cnt_r + 4'h1;
        end
      end
    end
  end

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = drv_r;
  assign addr_counter = addr_r;
  assign dev_active = state_r != ST_IDLE;
endmodule : eirp_dev
`default_nettype wire

// *** testbench/eirp_chk_sva.sv ***
// Concurrent checks on the two-wire bus between target and master
`timescale 1ns/1ps
`default_nettype none
module eirp_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bus lines
  input wire logic scl,
  input wire logic host_sda_o,
  input wire logic host_sda_oe,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // Start and stop are the only sda moves allowed with scl high
  sequence s_start;
    scl && $past(scl) && $fell(sda);
  endsequence
  sequence s_stop;
    scl && $past(scl) && $rose(sda);
  endsequence
  property p_reset_idle;
    !$past(rst_n) |-> scl && !host_sda_oe && !dev_sda_oe;
  endproperty
  a_reset_idle: assert property (p_reset_idle) else $error("bus not idle after reset");
  property p_dev_change_low;
    $changed(dev_sda_oe) |-> !scl && !$past(scl, 2);
  endproperty
  a_dev_change_low: assert property (p_dev_change_low) else $error("device moved sda near scl high");
  property p_no_clash;
    scl |-> !(host_sda_oe && dev_sda_oe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive sda with scl high");
  property p_start_release;
    s_start |-> ##2 (!dev_sda_oe) [*8];
  endproperty
  a_start_release: assert property (p_start_release) else $error("device drives after start");
  property p_stop_release;
    s_stop |=> (!dev_sda_oe) [*8];
  endproperty
  a_stop_release: assert property (p_stop_release) else $error("device drives after stop");
  property p_scl_low;
    $fell(scl) |-> (!scl) [*8];
  endproperty
  a_scl_low: assert property (p_scl_low) else $error("scl low phase too short");
  property p_scl_high;
    $rose(scl) |-> scl [*8];
  endproperty
  a_scl_high: assert property (p_scl_high) else $error("scl high phase too short");
  property p_open_drain;
    dev_sda_oe |-> !dev_sda_o && !sda;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("device drive is not a low level");
  c_start: cover property (s_start);
  c_stop: cover property (s_stop);
  c_dev_drive: cover property ($rose(dev_sda_oe));
  c_host_ack: cover property (scl && host_sda_oe && !dev_sda_oe);
endmodule : eirp_chk
`default_nettype wire

// *** testbench/test_eeprom_i2c_read_path.sv ***
// Register level bench: master and target joined over the two-wire bus
`timescale 1ns/1ps
`default_nettype none
module test_eeprom_i2c_read_path;
  import eirp_pkg::*;
  localparam int LIM = 40000;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
  logic [AXI_AW-1:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  logic wp = 1'b1, wbusy = 1'b0, locked = 1'b0;
  logic ld_en = 1'b0, ld_id = 1'b0;
  logic [MEM_AW-1:0] ld_addr = '0;
  logic [MEM_AW-1:0] counter;
  logic dev_act;
  logic [7:0] ld_data = '0;
  int n_errors = 0;
  int total_checks = 0;
  always #(CLK_NS / 2) clk_sys = ~clk_sys;
  eirp_if eirp_if_i ();
  eirp_host eirp_host_i (.clk_sys(clk_sys), .rst_n(rst_n),
    .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .bus(eirp_if_i));
  // Chip enable pins strapped to {high,low} = 2'b10
  eirp_dev eirp_dev_i (.clk_sys(clk_sys), .rst_n(rst_n), .bus(eirp_if_i),
    .chip_enable_pin_low(1'b0), .chip_enable_pin_high(1'b1),
    .write_protect_input(wp), .write_busy(wbusy), .ident_locked(locked),
    .load_en(ld_en), .load_id(ld_id), .load_addr(ld_addr), .load_data(ld_data),
    .addr_counter(counter), .dev_active(dev_act));
  eirp_chk eirp_chk_i (.clk_sys(clk_sys), .rst_n(rst_n), .scl(eirp_if_i.scl),
    .host_sda_o(eirp_if_i.host_sda_o), .host_sda_oe(eirp_if_i.host_sda_oe),
    .dev_sda_o(eirp_if_i.dev_sda_o), .dev_sda_oe(eirp_if_i.dev_sda_oe),
    .sda(eirp_if_i.sda));
  task automatic close_out();
    if (n_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : close_out
  task automatic tick(inout int n);
    @(posedge clk_sys);
    n++;
    if (n > LIM) begin
      n_errors++;
      close_out();
    end
  endtask : tick
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    logic aw_ok, w_ok;
    n = 0;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    awv <= 1'b1;
    awaddr <= a;
    wv <= 1'b1;
    wdata <= d;
    bready <= 1'b1;
    while (!(aw_ok && w_ok)) begin
      tick(n);
      if (awv && awready === 1'b1) begin
        aw_ok = 1'b1;
        awv <= 1'b0;
      end
      if (wv && wready === 1'b1) begin
        w_ok = 1'b1;
        wv <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) tick(n);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_wr
  task automatic axi_rd(input logic [AXI_AW-1:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    arv <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do tick(n); while (arready !== 1'b1);
    arv <= 1'b0;
    do tick(n); while (rvalid !== 1'b1);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
    @(posedge clk_sys);
  endtask : axi_rd
  // One byte a clock; ld_en is lowered by the caller after the last one
  task automatic load(input logic id, input logic [16:0] a, input logic [7:0] d);
    ld_en <= 1'b1;
    ld_id <= id;
    ld_addr <= a;
    ld_data <= d;
    @(posedge clk_sys);
  endtask : load
  task automatic run_op(input logic [1:0] op, input logic id, input logic [1:0] ce,
                        input logic [7:0] len1, input logic [16:0] a, input logic use_rd,
                        input logic [7:0] exp_rd, input logic [31:0] exp_st);
    int k;
    k = 0;
    axi_wr(REG_ADDR, {15'h0000, a}, resp);
    axi_wr(REG_CMD, {16'h0000, len1, 2'b00, ce, 1'b0, id, op}, resp);
    do begin
      axi_rd(REG_STAT, rd, resp);
      k++;
      if (k > LIM / 4) begin
        n_errors++;
        close_out();
      end
    end while (rd[STAT_BUSY] !== 1'b0);
    // Count, locked, nack and busy fields only
    chk("stat", exp_st, rd & 32'h0001_FF07);
    chk("dev_active", 32'h0000_0000, {31'h0, dev_act});
    if (use_rd) begin
      axi_rd(REG_RDATA, rd, resp);
      chk("rdata", {24'h000000, exp_rd}, rd);
    end
  endtask : run_op
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    load(1'b0, 17'h1FFFF, 8'hA5);
    load(1'b0, 17'h00000, 8'h5A);
    load(1'b0, 17'h00001, 8'h12);
    load(1'b1, 17'h000FF, 8'h77);
    ld_en <= 1'b0;
    @(posedge clk_sys);
    axi_rd(5'h10, rd, resp);
    chk("unmapped rresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    chk("unmapped rdata", 32'h0000_0000, rd);
    axi_wr(5'h14, 32'h0000_0000, resp);
    chk("unmapped bresp", {30'h0, RESP_SLVERR}, {30'h0, resp});
    // Write protect held high for every read
    run_op(OP_RAND, 1'b0, 2'b10, 8'h00, 17'h1FFFF, 1'b1, 8'hA5, 32'h100);
    chk("counter", 32'h0000_0000, {15'h0000, counter});
    run_op(OP_CUR, 1'b0, 2'b10, 8'h01, 17'h00000, 1'b1, 8'h12, 32'h200);
    chk("counter", 32'h0000_0002, {15'h0000, counter});
    run_op(OP_RAND, 1'b0, 2'b10, 8'h02, 17'h1FFFE, 1'b1, 8'h5A, 32'h300);
    chk("counter", 32'h0000_0001, {15'h0000, counter});
    run_op(OP_RAND, 1'b0, 2'b01, 8'h00, 17'h00000, 1'b0, 8'h00, 32'h002);
    run_op(OP_LOCK, 1'b1, 2'b10, 8'h00, 17'h00000, 1'b0, 8'h00, 32'h000);
    locked <= 1'b1;
    run_op(OP_LOCK, 1'b1, 2'b10, 8'h00, 17'h00000, 1'b0, 8'h00, 32'h004);
    // High address bits are junk on purpose; four bytes asked, one left in the page
    run_op(OP_RAND, 1'b1, 2'b10, 8'h03, 17'h123FF, 1'b1, 8'h77, 32'h100);
    chk("counter", 32'h0000_0100, {15'h0000, counter});
    run_op(OP_CUR, 1'b0, 2'b10, 8'h00, 17'h00000, 1'b1, 8'hFF, 32'h100);
    chk("counter", 32'h0000_0101, {15'h0000, counter});
    wbusy <= 1'b1;
    run_op(OP_CUR, 1'b0, 2'b10, 8'h00, 17'h00000, 1'b0, 8'h00, 32'h002);
    close_out();
  end
endmodule : test_eeprom_i2c_read_path
`default_nettype wire
